// file: emu_port_regs.svh
// constants for the emulation memory bus port: strap codes, pin masks, bit positions, timing
`ifndef EMU_PORT_REGS_SVH
`define EMU_PORT_REGS_SVH

`define STRAP_4K          2'b00
`define STRAP_8K          2'b01
`define STRAP_16K         2'b10
`define STRAP_32K         2'b11
`define HIGH_MASK_4K      8'h0f
`define HIGH_MASK_8K      8'h1f
`define HIGH_MASK_16K     8'h3f
`define HIGH_MASK_32K     8'h7f
`define EXT_WR_BIT        0
`define EXT_RD_BIT        1
`define EXT_LCME_BIT      2
`define EXT_LPSE_BIT      3
`define PAGE_SEL_BIT      7
`define PAGE_RESET        8'h00
`define PAGE_HIGH_RESET   8'h00
`define EXT_IDLE_NIBBLE   4'h0
`define SPACE_SFR         1'b0
`define ADDR_PHASE_CYCLES 4'h1
`define DATA_PHASE_CYCLES 4'h4

`endif

// file: emu_port_pkg.sv
// types shared by the emulation memory bus port
package emu_port_pkg;

  typedef enum logic [4:0]
  {
    KIND_FETCH     = 5'b00001,
    KIND_MOVC_DPTR = 5'b00010,
    KIND_MOVX_DPTR = 5'b00100,
    KIND_MOVX_RI   = 5'b01000,
    KIND_OTHER     = 5'b10000
  } access_kind_type;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } bus_state_type;

endpackage

// file: pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage;

  // no reset: the stages flush within two edges, so hold rst_n for at least three
  always_ff @(posedge sys_clk)
  begin
    stage  <= raw;
    synced <= stage;
  end

endmodule // pin_sync

// file: emu_bus_port.sv
// device-side pin logic of the emulation memory and emulation access buses
`timescale 1ns/1ps
`include "emu_port_regs.svh"
module emu_bus_port #(
  parameter logic [3:0] ADDR_CYCLES = `ADDR_PHASE_CYCLES,
  parameter logic [3:0] DATA_CYCLES = `DATA_PHASE_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         core_emu_mode,
  input  wire logic                         core_req,
  input  wire emu_port_pkg::access_kind_type core_kind,
  input  wire logic [15:0]                  core_addr,
  input  wire logic                         core_write,
  input  wire logic [7:0]                   core_wdata,
  output logic                              core_done,
  output logic [7:0]                        core_rdata,
  output logic                              core_busy,
  input  wire logic                         core_local_code_sel,
  input  wire logic                         page_wr,
  input  wire logic [7:0]                   page_wdata,
  input  wire logic                         page_high_wr,
  input  wire logic [7:0]                   page_high_wdata,
  output logic [7:0]                        extended_code_page_reg,
  output logic [7:0]                        page_high_reg,
  input  wire logic [7:0]                   core_emu_rdata,
  output logic                              emu_reg_write,
  output logic                              emu_reg_read,
  output logic [7:0]                        emu_addr,
  output logic                              emu_space,
  output logic [7:0]                        emu_wdata,
  output logic                              standard_variant,
  output logic [1:0]                        mem_size,
  input  wire logic [7:0]                   core_port3_out,
  input  wire logic [7:0]                   core_port3_oe,
  output logic [7:0]                        port3_out,
  output logic [7:0]                        port3_oe,
  input  wire logic                         standard_variant_select_n,
  input  wire logic                         mem_size_strap_hi,
  input  wire logic                         mem_size_strap_lo,
  input  wire logic                         space_select_line,
  input  wire logic [7:0]                   low_addr_data_bus_in,
  output logic [7:0]                        low_addr_data_bus_out,
  output logic [7:0]                        low_addr_data_bus_oe,
  input  wire logic [7:0]                   low_addr_bus_in,
  output logic [7:0]                        low_addr_bus_out,
  output logic [7:0]                        low_addr_bus_oe,
  input  wire logic [7:0]                   high_addr_bus_in,
  output logic [7:0]                        high_addr_bus_out,
  output logic [7:0]                        high_addr_bus_oe,
  input  wire logic [3:0]                   extended_bus_in,
  output logic [3:0]                        extended_bus_out,
  output logic [3:0]                        extended_bus_oe
);

  // pins visible on the high bus for each strap code
  function automatic logic [7:0] size_mask(input logic [1:0] strap);
    logic [7:0] m;
    m = `HIGH_MASK_4K;
    case (strap)
      `STRAP_4K:  m = `HIGH_MASK_4K;
      `STRAP_8K:  m = `HIGH_MASK_8K;
      `STRAP_16K: m = `HIGH_MASK_16K;
      default:    m = `HIGH_MASK_32K;
    endcase
    return m;
  endfunction

  // one active-low select out of four
  function automatic logic [3:0] decode_cs(input logic [1:0] code);
    logic [3:0] cs;
    cs = 4'hf;
    cs[code] = 1'b0;
    return cs;
  endfunction

  logic [22:0] pins_raw;
  logic [22:0] pins_sync;
  logic        s_std_n;
  logic [1:0]  s_strap;
  logic        s_space_select_line;
  logic        s_wr;
  logic        s_rd;
  logic        s_space;
  logic [7:0]  s_lab;
  logic [7:0]  s_lad;
  logic        straps_taken;
  logic        wr_prev;
  logic        rd_prev;
  logic        space_select_line_low;

  emu_port_pkg::bus_state_type   state;
  emu_port_pkg::access_kind_type acc_kind;
  logic [3:0]  phase_count;
  logic [15:0] acc_addr;
  logic        acc_write;
  logic [7:0]  acc_wdata;
  logic [7:0]  acc_high;
  logic [3:0]  acc_nibble;
  logic        acc_dptr;
  logic        acc_code_read;

  logic [7:0]  next_lad_out;
  logic [7:0]  next_lad_oe;
  logic [7:0]  next_lab_out;
  logic [7:0]  next_lab_oe;
  logic [7:0]  next_hab_out;
  logic [7:0]  next_hab_oe;
  logic [3:0]  next_ext_out;
  logic [3:0]  next_ext_oe;

  // every pin that the emulator or the board drives is synchronised before use
  assign pins_raw = {standard_variant_select_n, mem_size_strap_hi, mem_size_strap_lo,
                     space_select_line, extended_bus_in[`EXT_RD_BIT],
                     extended_bus_in[`EXT_WR_BIT], high_addr_bus_in[0],
                     low_addr_bus_in, low_addr_data_bus_in};

  pin_sync #(
    .WIDTH (23)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .raw     (pins_raw),
    .synced  (pins_sync)
  );

  assign s_std_n  = pins_sync[22];
  assign s_strap  = pins_sync[21:20];
  assign s_space_select_line   = pins_sync[19];
  assign s_rd     = pins_sync[18];
  assign s_wr     = pins_sync[17];
  assign s_space  = pins_sync[16];
  assign s_lab    = pins_sync[15:8];
  assign s_lad    = pins_sync[7:0];
  assign space_select_line_low = core_emu_mode && !s_space_select_line;

  // variant and straps are caught once after reset release, never under reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      straps_taken     <= 1'b0;
      standard_variant <= 1'b0;
      mem_size         <= `STRAP_4K;
    end
    else if (!straps_taken)
    begin
      straps_taken     <= 1'b1;
      standard_variant <= !s_std_n;
      mem_size         <= s_strap;
    end
  end

  // page registers written by the core; select bit clears on reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      extended_code_page_reg <= `PAGE_RESET;
      page_high_reg          <= `PAGE_HIGH_RESET;
    end
    else
    begin
      if (page_wr)
        extended_code_page_reg <= page_wdata;
      if (page_high_wr)
        page_high_reg <= page_high_wdata;
    end
  end

  // port three follows the core only outside emulation
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      port3_out <= 8'h00;
      port3_oe  <= 8'h00;
    end
    else if (!core_emu_mode)
    begin
      port3_out <= core_port3_out;
      port3_oe  <= core_port3_oe;
    end
  end

  // external access sequencer: address phase, then data phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state       <= emu_port_pkg::ST_IDLE;
      phase_count <= 4'h0;
      acc_kind    <= emu_port_pkg::KIND_OTHER;
      acc_addr    <= 16'h0000;
      acc_write   <= 1'b0;
      acc_wdata   <= 8'h00;
    end
    else
    begin
      case (state)
        emu_port_pkg::ST_IDLE:
        begin
          // requests in emulation are ignored: the core is halted then
          if (core_req && !core_emu_mode)
          begin
            state       <= emu_port_pkg::ST_ADDR;
            phase_count <= ADDR_CYCLES - 4'h1;
            acc_kind    <= core_kind;
            acc_addr    <= core_addr;
            acc_write   <= core_write;
            acc_wdata   <= core_wdata;
          end
        end
        emu_port_pkg::ST_ADDR:
        begin
          if (phase_count == 4'h0)
          begin
            state       <= emu_port_pkg::ST_DATA;
            phase_count <= DATA_CYCLES - 4'h1;
          end
          else
            phase_count <= phase_count - 4'h1;
        end
        emu_port_pkg::ST_DATA:
        begin
          if (phase_count == 4'h0)
            state <= emu_port_pkg::ST_IDLE;
          else
            phase_count <= phase_count - 4'h1;
        end
        default:
          state <= emu_port_pkg::ST_IDLE;
      endcase
    end
  end

  // completion pulse and read data; data is the synchronised bus, so the data
  // phase must cover the two-flop latency
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      core_done  <= 1'b0;
      core_rdata <= 8'h00;
      core_busy  <= 1'b0;
    end
    else
    begin
      core_done <= (state == emu_port_pkg::ST_DATA) && (phase_count == 4'h0);
      core_busy <= (state != emu_port_pkg::ST_IDLE) || (core_req && !core_emu_mode);
      if ((state == emu_port_pkg::ST_DATA) && (phase_count == 4'h0) && !acc_write)
        core_rdata <= s_lad;
    end
  end

  assign acc_dptr = (acc_kind == emu_port_pkg::KIND_MOVC_DPTR) ||
                    (acc_kind == emu_port_pkg::KIND_MOVX_DPTR);
  assign acc_code_read = (acc_kind == emu_port_pkg::KIND_FETCH) ||
                         (acc_kind == emu_port_pkg::KIND_MOVC_DPTR);
  // in the advanced variant, indirect register moves take the high byte from the page register
  assign acc_high = (acc_kind == emu_port_pkg::KIND_MOVX_RI) ? page_high_reg :
                    acc_addr[15:8];
  assign acc_nibble = (acc_dptr && (state != emu_port_pkg::ST_IDLE)) ?
                      extended_code_page_reg[3:0] : `EXT_IDLE_NIBBLE;

  // pin drive selection for the coming cycle
  always_comb
  begin
    next_lad_out = 8'h00;
    next_lad_oe  = 8'h00;
    next_lab_out = 8'h00;
    next_lab_oe  = 8'h00;
    next_hab_out = 8'h00;
    next_hab_oe  = 8'h00;
    next_ext_out = 4'h0;
    next_ext_oe  = 4'h0;
    if (core_emu_mode)
    begin
      // address, selector and strobes are inputs; data drives only on a read
      if (space_select_line_low && !s_rd)
      begin
        next_lad_out = core_emu_rdata;
        next_lad_oe  = 8'hff;
      end
    end
    else
    begin
      // address phase puts the low byte on the shared bus, data phase the data of a write
      if (state == emu_port_pkg::ST_ADDR)
      begin
        next_lad_out = acc_addr[7:0];
        next_lad_oe  = 8'hff;
      end
      else if ((state == emu_port_pkg::ST_DATA) && acc_write)
      begin
        next_lad_out = acc_wdata;
        next_lad_oe  = 8'hff;
      end
      next_lab_out = acc_addr[7:0];
      next_lab_oe  = 8'hff;
      if (standard_variant)
      begin
        next_hab_out = acc_addr[15:8] & size_mask(mem_size);
        next_hab_oe  = size_mask(mem_size);
        next_ext_out[`EXT_LCME_BIT] = core_local_code_sel;
        next_ext_out[`EXT_LPSE_BIT] = !((state == emu_port_pkg::ST_DATA) &&
                                        acc_code_read && !acc_write);
        next_ext_oe[`EXT_LCME_BIT]  = 1'b1;
        next_ext_oe[`EXT_LPSE_BIT]  = 1'b1;
      end
      else
      begin
        next_hab_out = acc_high;
        next_hab_oe  = 8'hff;
        next_ext_oe  = 4'hf;
        if (extended_code_page_reg[`PAGE_SEL_BIT])
          next_ext_out = decode_cs(acc_high[7:6]);
        else
          next_ext_out = acc_nibble;
      end
    end
  end

  // pin registers: floating in emulation follows from the zero enables
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      low_addr_data_bus_out <= 8'h00;
      low_addr_data_bus_oe  <= 8'h00;
      low_addr_bus_out      <= 8'h00;
      low_addr_bus_oe       <= 8'h00;
      high_addr_bus_out     <= 8'h00;
      high_addr_bus_oe      <= 8'h00;
      extended_bus_out      <= 4'h0;
      extended_bus_oe       <= 4'h0;
    end
    else
    begin
      low_addr_data_bus_out <= next_lad_out;
      low_addr_data_bus_oe  <= next_lad_oe;
      low_addr_bus_out      <= next_lab_out;
      low_addr_bus_oe       <= next_lab_oe;
      high_addr_bus_out     <= next_hab_out;
      high_addr_bus_oe      <= next_hab_oe;
      extended_bus_out      <= next_ext_out;
      extended_bus_oe       <= next_ext_oe;
    end
  end

  // emulator strobes are active low; the falling edge takes address and data
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_prev       <= 1'b1;
      rd_prev       <= 1'b1;
      emu_reg_write <= 1'b0;
      emu_reg_read  <= 1'b0;
      emu_addr      <= 8'h00;
      emu_space     <= `SPACE_SFR;
      emu_wdata     <= 8'h00;
    end
    else
    begin
      wr_prev       <= s_wr;
      rd_prev       <= s_rd;
      emu_reg_write <= space_select_line_low && wr_prev && !s_wr;
      emu_reg_read  <= space_select_line_low && rd_prev && !s_rd;
      if (space_select_line_low && ((wr_prev && !s_wr) || (rd_prev && !s_rd)))
      begin
        emu_addr  <= s_lab;
        emu_space <= s_space;
        emu_wdata <= s_lad;
      end
    end
  end

endmodule // emu_bus_port

// file: emu_bus_port_assertions.sv
// property checker for the emulation memory bus port pins
`timescale 1ns/1ps
module emu_bus_port_assertions #(
  parameter logic [3:0] ADDR_CYCLES = 4'h1,
  parameter logic [3:0] DATA_CYCLES = 4'h4
) (
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  input wire logic                          core_emu_mode,
  input wire logic                          core_req,
  input wire emu_port_pkg::access_kind_type core_kind,
  input wire logic [15:0]                   core_addr,
  input wire logic                          core_done,
  input wire logic                          core_busy,
  input wire logic [7:0]                    extended_code_page_reg,
  input wire logic [7:0]                    page_high_reg,
  input wire logic                          emu_reg_write,
  input wire logic                          emu_reg_read,
  input wire logic [7:0]                    emu_addr,
  input wire logic                          emu_space,
  input wire logic                          standard_variant,
  input wire logic [1:0]                    mem_size,
  input wire logic                          space_select_line,
  input wire logic [7:0]                    low_addr_data_bus_out,
  input wire logic [7:0]                    low_addr_data_bus_oe,
  input wire logic [7:0]                    low_addr_bus_in,
  input wire logic [7:0]                    low_addr_bus_out,
  input wire logic [7:0]                    low_addr_bus_oe,
  input wire logic [7:0]                    high_addr_bus_in,
  input wire logic [7:0]                    high_addr_bus_out,
  input wire logic [7:0]                    high_addr_bus_oe,
  input wire logic [3:0]                    extended_bus_out,
  input wire logic [3:0]                    extended_bus_oe
);
  localparam int LAT1 = ADDR_CYCLES + DATA_CYCLES;
  logic       acc;
  logic [7:0] next_hi, cap_lo, cap_hi, std_mask;
  logic [3:0] next_ext, cap_ext;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // expected pin values, worked out when a core access is taken
  assign acc = core_req && !core_busy && !core_emu_mode && !core_done;
  assign next_hi = (core_kind == emu_port_pkg::KIND_MOVX_RI) ? page_high_reg : core_addr[15:8];
  assign next_ext = extended_code_page_reg[7] ? ~(4'h1 << next_hi[7:6])
                  : (core_kind == emu_port_pkg::KIND_MOVC_DPTR ||
                     core_kind == emu_port_pkg::KIND_MOVX_DPTR) ? extended_code_page_reg[3:0]
                  : 4'h0;
  assign std_mask = 8'hff >> (3'd4 - {1'b0, mem_size});

  // held for the whole access, the design samples the core request inputs only once
  always_ff @(posedge sys_clk)
  begin
    if (acc)
    begin
      cap_lo  <= core_addr[7:0];
      cap_hi  <= next_hi;
      cap_ext <= next_ext;
    end
  end

  sequence s_done;
    ##LAT1 core_done ##1 !core_done;
  endsequence
  sequence s_float;
    (core_emu_mode && space_select_line)[*5];
  endsequence
  sequence s_emu_low;
    (core_emu_mode && !space_select_line)[*5];
  endsequence

  chk_access_time: assert property (acc |-> ##1 core_busy ##0 s_done)
    else $error("core access did not finish on time");
  chk_addr_phase: assert property (acc |-> ##[1:2] (low_addr_data_bus_oe == 8'hff
    && low_addr_data_bus_out == cap_lo && low_addr_bus_oe == 8'hff && low_addr_bus_out == cap_lo))
    else $error("low address byte not driven");
  chk_high_adv: assert property (acc && !standard_variant |-> ##[1:2]
    (high_addr_bus_oe == 8'hff && high_addr_bus_out == cap_hi))
    else $error("advanced high address byte wrong");
  chk_high_std: assert property (acc && standard_variant |-> ##[1:2]
    (high_addr_bus_oe == std_mask && ((high_addr_bus_out ^ cap_hi) & std_mask) == 8'h00))
    else $error("standard high address pins wrong");
  chk_ext_nibble: assert property (acc && !standard_variant |-> ##[1:2]
    (extended_bus_out == cap_ext && extended_bus_oe == 4'hf))
    else $error("extended bus value wrong during access");
  chk_ext_idle: assert property ((!standard_variant && !core_emu_mode && !core_busy
    && !extended_code_page_reg[7])[*4] |-> extended_bus_out == 4'h0)
    else $error("extended bus not zero while idle");
  chk_std_store: assert property (acc && standard_variant
    && core_kind == emu_port_pkg::KIND_FETCH |-> ##[2:4] (!extended_bus_out[3] && extended_bus_oe[3]))
    else $error("local program store enable not low in fetch");
  chk_emu_float: assert property (s_float |-> (low_addr_data_bus_oe | low_addr_bus_oe
    | high_addr_bus_oe) == 8'h00 && extended_bus_oe == 4'h0)
    else $error("buses not floating with space line high");
  chk_emu_inputs: assert property (s_emu_low |-> low_addr_bus_oe == 8'h00
    && !high_addr_bus_oe[0] && extended_bus_oe[1:0] == 2'h0)
    else $error("emulation input pins driven");
  chk_emu_capture: assert property (emu_reg_write || emu_reg_read |->
    emu_addr == low_addr_bus_in && emu_space == high_addr_bus_in[0] ##1 !(emu_reg_write || emu_reg_read))
    else $error("emulation access captured wrong address");
endmodule // emu_bus_port_assertions

bind emu_bus_port emu_bus_port_assertions #(
  .ADDR_CYCLES(ADDR_CYCLES),
  .DATA_CYCLES(DATA_CYCLES)
) u_chk (.*);

// file: emu_far_side.sv
// far-side model: emulator control logic and external memory
`timescale 1ns/1ps
module emu_far_side (
  input  wire logic       sys_clk,
  input  wire logic       core_emu_mode,
  input  wire logic [7:0] low_addr_data_bus_out,
  input  wire logic [7:0] low_addr_data_bus_oe,
  input  wire logic [7:0] low_addr_bus_out,
  input  wire logic [7:0] low_addr_bus_oe,
  input  wire logic [7:0] high_addr_bus_out,
  input  wire logic [7:0] high_addr_bus_oe,
  input  wire logic [3:0] extended_bus_out,
  input  wire logic [3:0] extended_bus_oe,
  output logic            space_select_line = 1'b1,
  output logic [7:0]      low_addr_data_bus_in,
  output logic [7:0]      low_addr_bus_in,
  output logic [7:0]      high_addr_bus_in,
  output logic [3:0]      extended_bus_in
);
  logic [7:0] e_lo = 8'h00, e_hi = 8'h00, e_dat = 8'h00, pd = 8'h00, pl = 8'h00, ph = 8'h00;
  logic [3:0] e_ext = 4'hf, pe = 4'h0;
  logic       e_dd = 1'b0;
  logic [7:0] far_d;

  // memory answers from the held low address; released lines show the inverse of last level
  assign far_d = core_emu_mode ? (e_dd ? e_dat : ~pd) : (low_addr_bus_out ^ 8'ha5);
  assign low_addr_data_bus_in = (low_addr_data_bus_oe & low_addr_data_bus_out)
                              | (~low_addr_data_bus_oe & far_d);
  assign low_addr_bus_in = (low_addr_bus_oe & low_addr_bus_out)
                         | (~low_addr_bus_oe & (core_emu_mode ? e_lo : ~pl));
  assign high_addr_bus_in = (high_addr_bus_oe & high_addr_bus_out)
                          | (~high_addr_bus_oe & (core_emu_mode ? e_hi : ~ph));
  assign extended_bus_in = (extended_bus_oe & extended_bus_out)
                         | (~extended_bus_oe & (core_emu_mode ? e_ext : ~pe));

  // last resolved levels, used for the released-line pattern
  always_ff @(posedge sys_clk)
  begin
    pd <= low_addr_data_bus_in;
    pl <= low_addr_bus_in;
    ph <= high_addr_bus_in;
    pe <= extended_bus_in;
  end

  // selector, address and data settle well before the strobe and stay past its release
  task automatic access(input logic wr, input logic sp, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    space_select_line = 1'b0;
    e_lo = a;
    e_hi = {7'h00, sp};
    e_dat = d;
    e_dd = wr;
    repeat (4) @(posedge sys_clk);
    #1 e_ext = wr ? 4'he : 4'hd;
    repeat (6) @(posedge sys_clk);
    q = low_addr_data_bus_in;
    #1 e_ext = 4'hf;
    repeat (5) @(posedge sys_clk);
    #1 e_dd = 1'b0;
    space_select_line = 1'b1;
    // let an edge pass so a following access never re-drives the line in the same step
    @(posedge sys_clk);
    #1;
  endtask
endmodule // emu_far_side

// file: emu_bus_port_tb.sv
// self-checking testbench for the emulation memory bus port
`timescale 1ns/1ps
module emu_bus_port_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n, core_emu_mode, core_req, core_write, core_done, core_busy;
  logic        core_local_code_sel, page_wr, page_high_wr, emu_reg_write, emu_reg_read;
  logic        emu_space, standard_variant, standard_variant_select_n, space_select_line;
  logic        mem_size_strap_hi, mem_size_strap_lo;
  logic [1:0]  mem_size;
  logic [3:0]  extended_bus_in, extended_bus_out, extended_bus_oe;
  logic [7:0]  core_wdata, core_rdata, page_wdata, page_high_wdata, extended_code_page_reg;
  logic [7:0]  page_high_reg, core_emu_rdata, emu_addr, emu_wdata, core_port3_out;
  logic [7:0]  core_port3_oe, port3_out, port3_oe, low_addr_data_bus_in, low_addr_data_bus_out;
  logic [7:0]  low_addr_data_bus_oe, low_addr_bus_in, low_addr_bus_out, low_addr_bus_oe;
  logic [7:0]  high_addr_bus_in, high_addr_bus_out, high_addr_bus_oe, q;
  logic [15:0] core_addr;
  emu_port_pkg::access_kind_type core_kind;
  int          num_errors = 0;
  int          checks_done = 0;
  int          wr_seen = 0;
  int          rd_seen = 0;

  emu_bus_port DUT (.*);
  emu_far_side far (.*);

  always #2.5 sys_clk = ~sys_clk;

  // emulator pulses last one cycle, so they are counted as they pass
  always @(posedge sys_clk)
  begin
    wr_seen += emu_reg_write;
    rd_seen += emu_reg_read;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // synchroniser has no reset, so the long hold also flushes it
  task automatic do_reset(input logic std_n, input logic [1:0] s);
    rst_n = 1'b0;
    core_emu_mode = 1'b0;
    standard_variant_select_n = std_n;
    {mem_size_strap_hi, mem_size_strap_lo} = s;
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic acc(input emu_port_pkg::access_kind_type k, input logic [15:0] a,
                     input logic w, input logic [7:0] d);
    int n;
    n = 0;
    core_kind = k;
    core_addr = a;
    core_write = w;
    core_wdata = d;
    core_req = 1'b1;
    @(posedge sys_clk);
    #1 core_req = 1'b0;
    while (core_done !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(16'(n < 40), 16'h0001);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic page(input logic [7:0] lo, input logic [7:0] hi);
    {page_wr, page_high_wr, page_wdata, page_high_wdata} = {2'b11, lo, hi};
    @(posedge sys_clk);
    #1 {page_wr, page_high_wr} = 2'b00;
  endtask

  task automatic t_advanced();
    logic [3:0] cs;
    do_reset(1'b1, 2'b00);
    repeat (6) @(posedge sys_clk);
    #1 chk(16'(standard_variant), 16'h0000);
    chk(16'(extended_code_page_reg), 16'h0000);
    acc(emu_port_pkg::KIND_FETCH, 16'h1234, 1'b0, 8'h00);
    chk(16'(core_rdata), 16'h0091);
    chk({high_addr_bus_out, low_addr_bus_out}, 16'h1234);
    page(8'h09, 8'h3c);
    chk({extended_code_page_reg, page_high_reg}, 16'h093c);
    acc(emu_port_pkg::KIND_MOVC_DPTR, 16'h5678, 1'b0, 8'h00);
    acc(emu_port_pkg::KIND_MOVX_DPTR, 16'habcd, 1'b1, 8'h6e);
    acc(emu_port_pkg::KIND_MOVX_RI, 16'h0042, 1'b0, 8'h00);
    chk(16'(high_addr_bus_out), 16'h003c);
    chk(16'(extended_bus_out), 16'h0000);
    page(8'h89, 8'h3c);
    for (int i = 0; i < 4; i++)
    begin
      cs = ~(4'h1 << i);
      acc(emu_port_pkg::KIND_MOVX_DPTR, {i[1:0], 14'h0155}, 1'b0, 8'h00);
      chk(16'(extended_bus_out), 16'(cs));
    end
    $display("test advanced done");
  endtask

  task automatic t_standard();
    for (int s = 0; s < 4; s++)
    begin
      do_reset(1'b0, s[1:0]);
      chk(16'({standard_variant, mem_size}), 16'(4 + s));
      core_local_code_sel = s[0];
      acc(emu_port_pkg::KIND_FETCH, 16'hfedc, 1'b0, 8'h00);
      chk(16'(core_rdata), 16'h0079);
      chk(16'(extended_bus_out[2]), 16'(s[0]));
    end
    core_local_code_sel = 1'b0;
    $display("test standard done");
  endtask

  task automatic t_emulation();
    int w0;
    int r0;
    do_reset(1'b1, 2'b00);
    core_port3_out = 8'h96;
    repeat (2) @(posedge sys_clk);
    #1 core_emu_mode = 1'b1;
    {core_port3_out, core_port3_oe} = 16'h690f;
    repeat (6) @(posedge sys_clk);
    #1 chk({port3_out, port3_oe}, 16'h96f0);
    chk(16'(low_addr_data_bus_oe | low_addr_bus_oe | high_addr_bus_oe), 16'h0000);
    chk(16'(extended_bus_oe), 16'h0000);
    w0 = wr_seen;
    r0 = rd_seen;
    far.access(1'b1, 1'b0, 8'h81, 8'h5e, q);
    chk({emu_wdata, emu_addr}, 16'h5e81);
    chk(16'({emu_space, 4'(wr_seen - w0)}), 16'h0001);
    far.access(1'b0, 1'b1, 8'h22, 8'h00, q);
    chk(16'(q), 16'h00c3);
    chk({3'h0, emu_space, emu_addr, 4'(rd_seen - r0)}, 16'h1221);
    chk({port3_out, port3_oe}, 16'h96f0);
    core_emu_mode = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk({port3_out, port3_oe}, 16'h690f);
    $display("test emulation done");
  endtask

  // the whole run needs about 320 cycles, the limit allows some thirty times that
  initial
  begin
    #50000;
    num_errors++;
    results();
  end

  initial
  begin
    {core_req, core_write, core_local_code_sel, page_wr, page_high_wr} = 5'h00;
    {core_addr, core_wdata, page_wdata, page_high_wdata} = 40'h0;
    {core_port3_out, core_port3_oe, core_emu_rdata} = 24'h00f0c3;
    core_kind = emu_port_pkg::KIND_OTHER;
    do_reset(1'b1, 2'b00);
    t_advanced();
    t_standard();
    t_emulation();
    results();
  end
endmodule // emu_bus_port_tb
